// File: hdl/rilc_regs.sv
`timescale 1ns/1ps
`include "rilc_cfg.svh"

// ****************************************************************
// Radio event status, interrupt and link configuration registers.
// ****************************************************************
module rilc_regs import rilc_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    // Register access port, fed by the command decoder.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire rilc_byte_type reg_wdata,
    output rilc_byte_type reg_rdata,
    // Event pulses from the baseband engine.
    input wire logic rx_packet_received,
    input wire logic tx_packet_sent,
    input wire logic resend_limit_reached,
    input wire logic signal_level_update_done,
    input wire logic payload_reuse_command,
    input wire logic tx_flush_command,
    // Queue levels.
    input wire logic rx_fifo_not_empty,
    input wire logic tx_fifo_empty,
    input wire logic tx_fifo_full,
    input wire rilc_queue_cond_type send_queue_condition_select,
    // Configuration towards the radio.
    output logic [1:0] group_address_size,
    output logic [2:0] group_address_bytes,
    output logic data_rate_select,
    output logic [1:0] output_power_select,
    output logic checksum_enable,
    output logic checksum_size,
    output logic [7:0] pipe_enables,
    output logic [7:0] pipe_auto_acks,
    output logic [7:0] pipe_variable_lengths,
    // Interrupt pin.
    output logic irq_pin
);
    // ****************************************************************
    // Helper functions.
    // ****************************************************************

    // Sticky flag update: a set in the same cycle beats the clear.
    function automatic logic sticky_next(input logic flag, input logic set, input logic clr);
        sticky_next = set | (flag & ~clr);
    endfunction

    // Address size code to a byte count; the forbidden code 00 reads as zero.
    function automatic logic [2:0] addr_bytes(input logic [1:0] code);
        addr_bytes = (code == 2'h0) ? 3'h0 : 3'({1'b0, code} + 3'h1);
    endfunction

    // ****************************************************************
    // Access decoding.
    // ****************************************************************

    // Write strobes for each mapped register.
    wire logic wr_status = reg_wr_en && (reg_addr == `RILC_ADDR_STATUS);
    wire logic wr_int_cfg = reg_wr_en && (reg_addr == `RILC_ADDR_INT_CFG);
    wire logic wr_bb_cfg = reg_wr_en && (reg_addr == `RILC_ADDR_BB_CFG);
    wire logic wr_pipe_en = reg_wr_en && (reg_addr == `RILC_ADDR_PIPE_EN);
    wire logic wr_auto_ack = reg_wr_en && (reg_addr == `RILC_ADDR_AUTO_ACK);
    wire logic wr_var_len = reg_wr_en && (reg_addr == `RILC_ADDR_VAR_LEN);

    // Write-one-to-clear requests on the status register.
    wire logic clr_rx_ready = wr_status && reg_wdata[`RILC_ST_RX_READY];
    wire logic clr_sent = wr_status && reg_wdata[`RILC_ST_SENT];
    wire logic clr_level = wr_status && reg_wdata[`RILC_ST_LEVEL];
    // The resend flag has two command clears on top of the write.
    wire logic clr_resend = (wr_status && reg_wdata[`RILC_ST_RESEND])
        || payload_reuse_command || tx_flush_command;

    // ****************************************************************
    // Status flags.
    // ****************************************************************

    logic rx_ready_ff; // Packet received, sticky.
    logic sent_ff; // Packet sent, sticky.
    logic resend_ff; // Resend limit hit, sticky.
    logic level_ff; // Signal level update done, sticky.
    logic queue_match_ff; // Send queue condition, live.
    logic rx_data_ff; // Receive queue holds data, live.

    // Next values of the sticky flags.
    wire logic nxt_rx_ready = sticky_next(rx_ready_ff, rx_packet_received, clr_rx_ready);
    wire logic nxt_sent = sticky_next(sent_ff, tx_packet_sent, clr_sent);
    wire logic nxt_resend = sticky_next(resend_ff, resend_limit_reached, clr_resend);
    wire logic nxt_level = sticky_next(level_ff, signal_level_update_done, clr_level);

    // Send queue condition chosen by the select field.
    wire logic nxt_queue_match =
        (send_queue_condition_select == RILC_Q_EMPTY) ? tx_fifo_empty :
        (send_queue_condition_select == RILC_Q_NOT_EMPTY) ? ~tx_fifo_empty :
        (send_queue_condition_select == RILC_Q_FULL) ? tx_fifo_full :
        ~tx_fifo_full;

    // Sticky event flags; only the named clears drop them.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_ready_ff <= 1'b0;
            sent_ff <= 1'b0;
            resend_ff <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            rx_ready_ff <= nxt_rx_ready;
            sent_ff <= nxt_sent;
            resend_ff <= nxt_resend;
            level_ff <= nxt_level;
        end
    end

    // Live flags follow their sources a cycle late and ignore writes.
    // Registering them gives reset values of one and zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            queue_match_ff <= 1'b1;
            rx_data_ff <= 1'b0;
        end else begin
            queue_match_ff <= nxt_queue_match;
            rx_data_ff <= rx_fifo_not_empty;
        end
    end

    // Status byte as software sees it; bits 7 and 6 are reserved zero.
    wire rilc_byte_type status_value = {2'h0, rx_ready_ff, sent_ff, resend_ff,
        level_ff, queue_match_ff, rx_data_ff};

    // ****************************************************************
    // Configuration registers.
    // ****************************************************************

    rilc_byte_type int_cfg_ff; // Interrupt polarity and enables.
    rilc_byte_type bb_cfg_ff; // Address size, rate, power, checksum.
    rilc_byte_type pipe_en_ff; // One enable per pipe.
    rilc_byte_type auto_ack_ff; // One auto acknowledge per pipe.
    rilc_byte_type var_len_ff; // One variable length enable per pipe.

    // Reserved bits are not stored, so a stray one written there
    // cannot reach the radio and always reads back as zero.
    wire rilc_byte_type nxt_int_cfg = reg_wdata & `RILC_MASK_INT_CFG;
    wire rilc_byte_type nxt_bb_cfg = reg_wdata & `RILC_MASK_BB_CFG;

    // Interrupt and baseband configuration writes.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_cfg_ff <= `RILC_RST_INT_CFG;
            bb_cfg_ff <= `RILC_RST_BB_CFG;
        end else begin
            if (wr_int_cfg) begin
                int_cfg_ff <= nxt_int_cfg;
            end
            if (wr_bb_cfg) begin
                bb_cfg_ff <= nxt_bb_cfg;
            end
        end
    end

    // Per-pipe enable registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pipe_en_ff <= `RILC_RST_PIPE_EN;
            auto_ack_ff <= `RILC_RST_AUTO_ACK;
            var_len_ff <= `RILC_RST_VAR_LEN;
        end else begin
            if (wr_pipe_en) begin
                pipe_en_ff <= reg_wdata;
            end
            if (wr_auto_ack) begin
                auto_ack_ff <= reg_wdata;
            end
            if (wr_var_len) begin
                var_len_ff <= reg_wdata;
            end
        end
    end

    // Configuration fields towards the radio.
    assign group_address_size = bb_cfg_ff[`RILC_BB_ADDR_HI:`RILC_BB_ADDR_LO];
    assign group_address_bytes = addr_bytes(group_address_size);
    assign data_rate_select = bb_cfg_ff[`RILC_BB_RATE];
    assign output_power_select = bb_cfg_ff[`RILC_BB_PWR_HI:`RILC_BB_PWR_LO];
    assign checksum_enable = bb_cfg_ff[`RILC_BB_CRC_EN];
    assign checksum_size = bb_cfg_ff[`RILC_BB_CRC_LEN];
    // Bit n of each pipe register serves pipe n+1.
    assign pipe_enables = pipe_en_ff;
    assign pipe_auto_acks = auto_ack_ff;
    assign pipe_variable_lengths = var_len_ff;

    // ****************************************************************
    // Read path.
    // ****************************************************************

    // Read selection; unmapped addresses read as zero.
    wire rilc_byte_type read_value =
        (reg_addr == `RILC_ADDR_STATUS) ? status_value :
        (reg_addr == `RILC_ADDR_INT_CFG) ? int_cfg_ff :
        (reg_addr == `RILC_ADDR_BB_CFG) ? bb_cfg_ff :
        (reg_addr == `RILC_ADDR_PIPE_EN) ? pipe_en_ff :
        (reg_addr == `RILC_ADDR_AUTO_ACK) ? auto_ack_ff :
        (reg_addr == `RILC_ADDR_VAR_LEN) ? var_len_ff :
        8'h00;

    rilc_byte_type rdata_ff; // Holds the last read until the next one.

    // Capture read data one cycle after the read strobe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_ff <= read_value;
        end
    end
    assign reg_rdata = rdata_ff;

    // ****************************************************************
    // Interrupt pin.
    // ****************************************************************

    // The receive-empty condition is the inverse of the live data flag.
    rilc_irq_pin u_irq_pin (
        .clk(clk),
        .rstn(rstn),
        .int_cfg(int_cfg_ff),
        .rx_ready(rx_ready_ff),
        .sent(sent_ff),
        .resend_limit(resend_ff),
        .txq_empty(tx_fifo_empty),
        .rxq_empty(~rx_data_ff),
        .level_done(level_ff),
        .irq_pin(irq_pin)
    );

    // ****************************************************************
    // Checks.
    // ****************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_level_flag_sticky: assert property (
        (level_ff && !clr_level) |=> level_ff
    ) else $error("Signal level flag dropped without a clear.");
    chk_level_flag_set: assert property (
        signal_level_update_done |=> level_ff
    ) else $error("Signal level flag not set by update.");
    chk_queue_state_live: assert property (
        ##1 queue_match_ff == $past(nxt_queue_match)
    ) else $error("Queue state bit does not track its condition.");
    chk_rx_data_follow: assert property (
        ##1 status_value[`RILC_ST_RX_DATA] == $past(rx_fifo_not_empty)
    ) else $error("Receive data bit does not follow the queue.");
    chk_rx_ready_set: assert property (
        rx_packet_received |=> rx_ready_ff ##0 status_value[`RILC_ST_RX_READY]
    ) else $error("Receive ready flag missed an event.");
    chk_sent_clear_w1c: assert property (
        (clr_sent && !tx_packet_sent) |=> !sent_ff
    ) else $error("Send done flag not cleared by write one.");
    chk_resend_cmd_clear: assert property (
        ((payload_reuse_command || tx_flush_command) && !resend_limit_reached)
        |=> !resend_ff
    ) else $error("Resend flag not cleared by command.");
    chk_bb_cfg_write: assert property (
        wr_bb_cfg |=> data_rate_select == $past(reg_wdata[`RILC_BB_RATE])
            && (bb_cfg_ff & ~`RILC_MASK_BB_CFG) == 8'h00
    ) else $error("Baseband configuration write not taken.");
    chk_pipe_write: assert property (
        wr_pipe_en |=> pipe_enables == $past(reg_wdata)
    ) else $error("Pipe enable write not taken.");
    chk_read_latency: assert property (
        reg_rd_en |=> reg_rdata == $past(read_value)
    ) else $error("Read data not returned one cycle later.");

    // Clears must drop each flag, and a set must win over a clear in the same cycle,
    // so that an event arriving while software acknowledges the last one is not lost.
    chk_level_flag_clear: assert property (
        (clr_level && !signal_level_update_done) |=> !level_ff
    ) else $error("Signal level flag not cleared by write one.");
    chk_rx_ready_clear: assert property (
        (clr_rx_ready && !rx_packet_received) |=> !rx_ready_ff
    ) else $error("Receive ready flag not cleared by write one.");
    chk_sent_set_wins: assert property (
        tx_packet_sent |=> sent_ff
    ) else $error("Send done flag missed an event.");
    chk_resend_flag_set: assert property (
        resend_limit_reached |=> resend_ff
    ) else $error("Resend flag missed an event.");

    // Configuration writes land one cycle later, reserved bits held at zero.
    chk_int_cfg_write: assert property (
        wr_int_cfg |=> int_cfg_ff == ($past(reg_wdata) & `RILC_MASK_INT_CFG)
    ) else $error("Interrupt configuration write not taken.");
    chk_auto_ack_write: assert property (
        wr_auto_ack |=> pipe_auto_acks == $past(reg_wdata)
    ) else $error("Auto acknowledge write not taken.");
    chk_var_len_write: assert property (
        wr_var_len |=> pipe_variable_lengths == $past(reg_wdata)
    ) else $error("Variable length write not taken.");
    // The four-byte code is the widest address the radio accepts.
    chk_addr_bytes_map: assert property (
        (group_address_size == 2'h3) |-> (group_address_bytes == 3'h4)
    ) else $error("Address size code does not give four bytes.");

    cov_rx_then_clear: cover property (rx_ready_ff ##1 clr_rx_ready ##1 !rx_ready_ff);
    cov_set_with_clear: cover property (tx_packet_sent && clr_sent);
    cov_flush_clears: cover property (resend_ff && tx_flush_command);
endmodule // rilc_regs

// File: hdl/rilc_cfg.svh
// Notes on behaviour
// - Signal level update flag, write one clears.
// - Status bit 1 tracks send queue condition.
// - Status bit 0 shows receive queue holds data.
// - Interrupt config bit 7 sets pin polarity.
// - Bit 5 enables interrupt on packet reception.
// - Bit 4 enables interrupt on packet sent.
// - Bit 3 enables interrupt on resend limit.
// - Bit 2 enables interrupt on send queue empty.
// - Bit 1 enables interrupt on receive queue empty.
// - Bit 0 enables interrupt on signal level update.
// - Group address size 01/10/11 means 2/3/4 bytes.
// - Data rate bit: 250 kbps or 2 Mbps.
// - Output power field maps four levels, lowest reset.
// - Checksum enable bit, enabled after reset.
// - Checksum size bit, two bytes after reset.
// - Auto acknowledge bits, all disabled at reset.
// - Variable length bits for pipes eight to six.
// - Variable length bits for pipes five to one.
// - Packet reception sets ready flag; write one clears.
// - Packet sent sets done flag; write one clears.
// - Resend limit flag, cleared by write, reuse, flush.
`ifndef RILC_CFG_SVH
`define RILC_CFG_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define RILC_ADDR_STATUS 8'h01
`define RILC_ADDR_INT_CFG 8'h02
`define RILC_ADDR_BB_CFG 8'h03
`define RILC_ADDR_PIPE_EN 8'h04
`define RILC_ADDR_AUTO_ACK 8'h05
`define RILC_ADDR_VAR_LEN 8'h06

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define RILC_RST_INT_CFG 8'h30
`define RILC_RST_BB_CFG 8'h33
`define RILC_RST_PIPE_EN 8'hFF
`define RILC_RST_AUTO_ACK 8'h00
`define RILC_RST_VAR_LEN 8'h00
`define RILC_MASK_INT_CFG 8'hBF
`define RILC_MASK_BB_CFG 8'h7F

// ****************************************************************
// Status bit positions.
// ****************************************************************
`define RILC_ST_RX_READY 5
`define RILC_ST_SENT 4
`define RILC_ST_RESEND 3
`define RILC_ST_LEVEL 2
`define RILC_ST_QUEUE 1
`define RILC_ST_RX_DATA 0

// ****************************************************************
// Interrupt configuration bit positions.
// ****************************************************************
`define RILC_IC_POLARITY 7
`define RILC_IC_RX 5
`define RILC_IC_SENT 4
`define RILC_IC_RESEND 3
`define RILC_IC_TXQ 2
`define RILC_IC_RXQ 1
`define RILC_IC_LEVEL 0

// ****************************************************************
// Baseband configuration field positions.
// ****************************************************************
`define RILC_BB_ADDR_HI 6
`define RILC_BB_ADDR_LO 5
`define RILC_BB_RATE 4
`define RILC_BB_PWR_HI 3
`define RILC_BB_PWR_LO 2
`define RILC_BB_CRC_EN 1
`define RILC_BB_CRC_LEN 0

`endif

// File: hdl/rilc_pkg.sv
// ****************************************************************
// Types shared by the register slice.
// ****************************************************************
package rilc_pkg;
    // One register byte.
    typedef logic [7:0] rilc_byte_type;
    // Send queue condition that status bit 1 reports.
    typedef enum logic [1:0] {
        RILC_Q_EMPTY = 2'h0,
        RILC_Q_NOT_EMPTY = 2'h1,
        RILC_Q_FULL = 2'h3,
        RILC_Q_NOT_FULL = 2'h2
    } rilc_queue_cond_type;
endpackage

// File: hdl/rilc_irq_pin.sv
`timescale 1ns/1ps
`include "rilc_cfg.svh"

// ****************************************************************
// Interrupt pin driver: gates conditions by enables, sets polarity.
// ****************************************************************
module rilc_irq_pin import rilc_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire rilc_byte_type int_cfg,
    input wire logic rx_ready,
    input wire logic sent,
    input wire logic resend_limit,
    input wire logic txq_empty,
    input wire logic rxq_empty,
    input wire logic level_done,
    output logic irq_pin
);
    // Each condition qualified by its own enable bit.
    wire logic hit_rx = rx_ready & int_cfg[`RILC_IC_RX];
    wire logic hit_sent = sent & int_cfg[`RILC_IC_SENT];
    wire logic hit_resend = resend_limit & int_cfg[`RILC_IC_RESEND];
    wire logic hit_txq = txq_empty & int_cfg[`RILC_IC_TXQ];
    wire logic hit_rxq = rxq_empty & int_cfg[`RILC_IC_RXQ];
    wire logic hit_level = level_done & int_cfg[`RILC_IC_LEVEL];
    // Any enabled condition asserts the pin.
    wire logic irq_active = hit_rx | hit_sent | hit_resend
        | hit_txq | hit_rxq | hit_level;
    // Polarity one drives high when active, zero drives low.
    wire logic nxt_irq_pin = int_cfg[`RILC_IC_POLARITY] ? irq_active : ~irq_active;
    logic irq_pin_ff; // Registered so the pin never glitches.

    // Register the pin; reset leaves it idle at the low-active default.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_pin_ff <= 1'b1;
        end else begin
            irq_pin_ff <= nxt_irq_pin;
        end
    end
    assign irq_pin = irq_pin_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_irq_polarity_level: assert property (
        ##1 irq_pin == ($past(int_cfg[`RILC_IC_POLARITY]) ~^ $past(irq_active))
    ) else $error("Interrupt pin level disagrees with polarity.");
    chk_irq_rx_assert: assert property (
        (rx_ready && int_cfg[`RILC_IC_RX]) |=> irq_pin == $past(int_cfg[`RILC_IC_POLARITY])
    ) else $error("Receive event did not assert the pin.");
    chk_irq_idle_release: assert property (
        !irq_active |=> irq_pin != $past(int_cfg[`RILC_IC_POLARITY])
    ) else $error("Pin asserted with no enabled condition.");
    cov_irq_high_active: cover property (int_cfg[`RILC_IC_POLARITY] && irq_pin);
endmodule // rilc_irq_pin

// File: tb/rilc_host_model.sv
`timescale 1ns/1ps
`include "rilc_cfg.svh"

// ****
// Host model: register writes and reads on the command port.
// ****
module rilc_host_model import rilc_pkg::*; (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output rilc_byte_type reg_wdata,
    input wire rilc_byte_type reg_rdata
);
    // Idle values are driven from time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end

    // One write, entered and left at a falling edge; reserved bits of the interrupt and baseband configuration go out as zero.
    // An idle edge follows, so a second call never re-raises the strobe it just lowered.
    task automatic write_reg(input logic [7:0] addr, input rilc_byte_type data);
        rilc_byte_type sent_data;
        sent_data = data;
        if (addr == `RILC_ADDR_INT_CFG) sent_data = data & `RILC_MASK_INT_CFG;
        if (addr == `RILC_ADDR_BB_CFG) sent_data = data & `RILC_MASK_BB_CFG;
        reg_addr = addr;
        reg_wdata = sent_data;
        reg_wr_en = 1'b1;
        @(posedge clk);
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_wdata = ~reg_wdata;
        @(negedge clk);
    endtask

    // One read; the registered data is settled by the next falling edge.
    task automatic read_reg(input logic [7:0] addr, output rilc_byte_type data);
        reg_addr = addr;
        reg_rd_en = 1'b1;
        @(posedge clk);
        @(negedge clk);
        reg_rd_en = 1'b0;
        data = reg_rdata;
        @(negedge clk);
    endtask
endmodule // rilc_host_model

// File: tb/tb_rilc_regs.sv
`timescale 1ns/1ps

// ****
// Bench for the register slice.
// ****
module tb_rilc_regs import rilc_pkg::*;;
    logic clk, rstn, rx_ne, txq_empty, txq_full, irq_pin, rate, ck_en, ck_size;
    logic [5:0] ev; // Event pulses: rx, sent, resend, level, reuse, flush.
    logic [7:0] addr, pen, pack, pvar;
    logic wr_en, rd_en;
    logic [1:0] gsize, pwr;
    logic [2:0] gbytes;
    rilc_byte_type wdata, rdata;
    rilc_queue_cond_type qsel;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    rilc_regs u_rilc_regs (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wdata), .reg_rdata(rdata),
        .rx_packet_received(ev[0]), .tx_packet_sent(ev[1]), .resend_limit_reached(ev[2]),
        .signal_level_update_done(ev[3]), .payload_reuse_command(ev[4]),
        .tx_flush_command(ev[5]), .rx_fifo_not_empty(rx_ne), .tx_fifo_empty(txq_empty),
        .tx_fifo_full(txq_full), .send_queue_condition_select(qsel),
        .group_address_size(gsize), .group_address_bytes(gbytes),
        .data_rate_select(rate), .output_power_select(pwr), .checksum_enable(ck_en),
        .checksum_size(ck_size), .pipe_enables(pen), .pipe_auto_acks(pack),
        .pipe_variable_lengths(pvar), .irq_pin(irq_pin));
    rilc_host_model u_rilc_host_model (.clk(clk), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wdata), .reg_rdata(rdata));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard: far above the roughly 150 cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    // Compare two values; an unknown never matches.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Read a register and compare it.
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        rilc_byte_type d;
        u_rilc_host_model.read_reg(a, d);
        check(d, exp);
    endtask

    // Reset values of every register and of the baseband, pin and pipe enable outputs, plus an unmapped offset.
    task automatic test_reset();
        logic [7:0] exp [7] = '{8'h02, 8'h30, 8'h33, 8'hFF, 8'h00, 8'h00, 8'h00};
        check({gbytes, rate, pwr, ck_en, ck_size}, 8'h53);
        check(irq_pin, 1'b1);
        check(pen, 8'hFF);
        for (int i = 0; i < 7; i++) rd_check(8'(i + 1), exp[i]);
    endtask

    // Every address size and power code, both rates and checksum settings.
    task automatic test_baseband();
        logic [7:0] v [4] = '{8'h20, 8'h47, 8'h79, 8'h3E};
        foreach (v[i]) begin
            u_rilc_host_model.write_reg(8'h03, v[i]);
            check({1'b0, gsize, rate, pwr, ck_en, ck_size}, v[i]);
            check(gbytes, v[i][6:5] + 3'd1);
            rd_check(8'h03, v[i]);
        end
    endtask

    // Pipe enable, auto acknowledge and variable length bytes.
    task automatic test_pipes();
        u_rilc_host_model.write_reg(8'h04, 8'h5A);
        u_rilc_host_model.write_reg(8'h05, 8'hA5);
        u_rilc_host_model.write_reg(8'h06, 8'hC3);
        check(pen, 8'h5A);
        check(pack, 8'hA5);
        check(pvar, 8'hC3);
        rd_check(8'h06, 8'hC3);
    endtask

    // Each sticky flag sets, drives the pin low, and clears by a write of one.
    task automatic test_flags();
        rx_ne = 1'b1;
        u_rilc_host_model.write_reg(8'h02, 8'h39);
        for (int k = 0; k < 4; k++) begin
            ev = 6'(1 << k);
            @(negedge clk) ev = 6'h00;
            @(negedge clk);
            check(irq_pin, 1'b0);
            rd_check(8'h01, 8'(8'h03 | (8'h20 >> k)));
            u_rilc_host_model.write_reg(8'h01, 8'h20 >> k);
            @(negedge clk);
            check(irq_pin, 1'b1);
            rd_check(8'h01, 8'h03);
        end
        for (int j = 4; j < 6; j++) begin
            ev = 6'h04;
            @(negedge clk) ev = 6'(1 << j);
            @(negedge clk) ev = 6'h00;
            rd_check(8'h01, 8'h03);
        end
    endtask

    // Live queue bits for every select code, then the pin at high polarity.
    task automatic test_live();
        logic [1:0] fifo [3] = '{2'b10, 2'b00, 2'b01};
        logic e, f, x;
        u_rilc_host_model.write_reg(8'h01, 8'h3C);
        foreach (fifo[i]) begin
            for (int s = 0; s < 4; s++) begin
                {e, f} = fifo[i];
                x = (s == 0) ? e : (s == 1) ? !e : (s == 3) ? f : !f;
                {txq_empty, txq_full, rx_ne} = {e, f, s[0]};
                qsel = rilc_queue_cond_type'(s[1:0]);
                @(negedge clk);
                rd_check(8'h01, {6'h00, x, s[0]});
            end
        end
        {txq_empty, rx_ne} = 2'b00;
        u_rilc_host_model.write_reg(8'h02, 8'h86);
        @(negedge clk);
        check(irq_pin, 1'b1);
        rx_ne = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check(irq_pin, 1'b0);
        txq_empty = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check(irq_pin, 1'b1);
    endtask

    // Verdict and end of run.
    task automatic complete_run();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset for five cycles, then every scenario in turn.
    initial begin
        {rstn, ev, rx_ne, txq_full, txq_empty} = 10'h001;
        qsel = RILC_Q_EMPTY;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        test_reset();
        test_baseband();
        test_pipes();
        test_flags();
        test_live();
        // Second reset in mid-run: every written register must return to reset.
        {rx_ne, txq_full, txq_empty} = 3'b001;
        qsel = RILC_Q_EMPTY;
        rstn = 1'b0;
        @(negedge clk) rstn = 1'b1;
        test_reset();
        complete_run();
    end
endmodule // tb_rilc_regs
